// *** hdl/dof_pkg.sv ***
// Constants shared by the decoder output formatter and its helpers.
// Assumes an 8-bit subaddress register port on the line-locked clock.
package dof_pkg;

	// ------------------------------------------------------------
	// Register subaddresses
	// ------------------------------------------------------------
	localparam logic [7:0] LINE_TYPE_FIRST_ADDR = 8'h41;
	localparam logic [7:0] LINE_TYPE_LAST_ADDR = 8'h57;
	localparam logic [7:0] HORIZONTAL_OFFSET_LOW_ADDR = 8'h59;
	localparam logic [7:0] VERTICAL_OFFSET_LOW_ADDR = 8'h5A;
	localparam logic [7:0] OFFSET_HIGH_AND_FIELD_FLAG_ADDR = 8'h5B;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int FIELD_OFFSET_FLAG_BIT = 7;
	localparam int FIELD_STATUS_BIT = 6;
	localparam int VERTICAL_LINE_OFFSET_HIGH_BIT = 4;
	localparam int HORIZONTAL_PIXEL_OFFSET_HIGH_MSB = 2;
	localparam logic [7:0] LINE_TYPE_RESET = 8'hFF;
	localparam logic [10:0] HORIZONTAL_PIXEL_OFFSET_RESET = 11'h347;
	localparam logic [8:0] VERTICAL_LINE_OFFSET_RESET = 9'h003;
	localparam logic FIELD_OFFSET_FLAG_RESET = 1'b0;

	// ------------------------------------------------------------
	// Line-type entries and data type codes
	// ------------------------------------------------------------
	localparam logic [4:0] ENTRY_FIRST = 5'h02;
	localparam logic [4:0] ENTRY_LAST_SINGLE = 5'h17;
	localparam logic [4:0] ENTRY_REST = 5'h18;
	localparam int ENTRY_COUNT = 23;
	localparam logic [3:0] TYPE_VBI_VIDEO = 4'h6;
	localparam logic [3:0] TYPE_RESERVED = 4'hB;
	localparam logic [3:0] TYPE_ACTIVE_VIDEO = 4'hF;

	// ------------------------------------------------------------
	// Stream codes and pin selections
	// ------------------------------------------------------------
	localparam logic [7:0] ITU_PREAMBLE_FF = 8'hFF;
	localparam logic [7:0] ITU_PREAMBLE_00 = 8'h00;
	localparam logic [7:0] ITU_BLANK_CHROMA = 8'h80;
	localparam logic [7:0] ITU_BLANK_LUMA = 8'h10;

	typedef enum logic [1:0] {
		RTS_HORIZONTAL_REFERENCE,
		RTS_VSYNC,
		RTS_VERTICAL_WINDOW_GATE,
		RTS_FID
	} dof_rts_sel_t;

endpackage

// *** hdl/dof_type_decode.sv ***
// Decodes a 4-bit line data type into the raw and VBI markers.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module dof_type_decode
	import dof_pkg::*;
(
	input wire logic [3:0] code,
	output logic raw_mark,
	output logic vbi_mark
);
	assign raw_mark = (code != TYPE_VBI_VIDEO) && (code != TYPE_ACTIVE_VIDEO);
	// VBI lines are all but active video
	assign vbi_mark = (code != TYPE_ACTIVE_VIDEO);
endmodule
`default_nettype wire

// *** hdl/dof_itu_fmt.sv ***
// ITU 656 byte stream builder for the expansion data port.
// Assumes input samples already in Cb Y Cr Y order, one per clock.
`timescale 1ns/1ps
`default_nettype none
module dof_itu_fmt
	import dof_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic horizontal_reference,
	input wire logic f_bit,
	input wire logic v_bit,
	input wire logic [7:0] data_in,
	input wire logic data_valid,
	output logic [7:0] xpd,
	output logic expansion_data_qualifier
);
	typedef enum logic [2:0] {
		FMT_BLANK, FMT_P1, FMT_P2, FMT_P3, FMT_ACTIVE
	} dof_fmt_state_t;

	dof_fmt_state_t st_r;
	logic horizontal_reference_d_r;
	logic eav_r;
	logic blank_phase_r;
	logic [7:0] xy;
	logic h_bit;

	assign h_bit = eav_r;
	// Protection bits let the receiver correct single errors
	assign xy = {1'b1, f_bit, v_bit, h_bit, v_bit ^ h_bit, f_bit ^ h_bit,
		f_bit ^ v_bit, f_bit ^ v_bit ^ h_bit};

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// timing codes framing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= FMT_BLANK;
			horizontal_reference_d_r <= 1'b0;
			eav_r <= 1'b0;
			blank_phase_r <= 1'b0;
			xpd <= ITU_BLANK_CHROMA;
			expansion_data_qualifier <= 1'b0;
		end else begin
			horizontal_reference_d_r <= horizontal_reference;
			blank_phase_r <= ~blank_phase_r;
			expansion_data_qualifier <= 1'b1;
			unique case (st_r)
				FMT_BLANK, FMT_ACTIVE: begin
					if (horizontal_reference != horizontal_reference_d_r) begin
						st_r <= FMT_P1;
						eav_r <= ~horizontal_reference;
						xpd <= ITU_PREAMBLE_FF;
					end else if (st_r == FMT_ACTIVE) begin
						xpd <= data_in;
						expansion_data_qualifier <= data_valid;
					end else begin
						xpd <= blank_phase_r ? ITU_BLANK_LUMA : ITU_BLANK_CHROMA;
					end
				end
				FMT_P1: begin
					st_r <= FMT_P2;
					xpd <= ITU_PREAMBLE_00;
				end
				FMT_P2: begin
					st_r <= FMT_P3;
					xpd <= ITU_PREAMBLE_00;
				end
				FMT_P3: begin
					// Samples arriving during the code are dropped
					st_r <= eav_r ? FMT_BLANK : FMT_ACTIVE;
					xpd <= xy;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// preamble after line start
	a_sav_preamble: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r == FMT_BLANK && horizontal_reference && !horizontal_reference_d_r) |=>
		xpd == ITU_PREAMBLE_FF ##1 xpd == ITU_PREAMBLE_00
		##1 xpd == ITU_PREAMBLE_00 ##1 xpd[7])
		else $error("start code not emitted");
	c_line_framed: cover property (@(posedge clk) disable iff (!rst_n)
		st_r == FMT_ACTIVE ##[1:1000] st_r == FMT_P3 && eav_r);
endmodule
`default_nettype wire

// *** hdl/dof_top.sv ***
// Decoder output formatter: line typing, reference routing, ITU 656 out.
// Assumes decoder references and samples synchronous to MCLK.
//
// Notes on behaviour
// - Expansion data leaves as ITU 656; reference pins are selected here.
// - Raw and VBI markers come from the current line's data type.
// - Entries 2 to 23 per line; entry 24 covers the field's rest.
// - Upper nibble serves field 1, lower nibble field 2.
// - Nine-bit vertical offset plus field offset flag shift line mapping.
// - Codes 6 and 15 give 4:2:2, all other codes give raw samples.
// - 525-line setup maps entries 2-9 into the second field's early lines.
// - 625-line setup maps entries from line 1 and 3 to 23 onward.
// - Eleven-bit horizontal pixel offset split over 5BH and 59H.
// - Horizontal reference high at vertical sync fall marks odd field.
// - Selectable routing of references to real-time status pins and the vertical expansion pin.
// - Line-type entries live at subaddresses 41H to 57H.
`timescale 1ns/1ps
`default_nettype none
module dof_top
	import dof_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic HORIZONTAL_REFERENCE,
	input wire logic VERTICAL_SYNC_PULSE,
	input wire logic VERTICAL_WINDOW_GATE,
	input wire logic [7:0] VIDEO_DATA,
	input wire logic VIDEO_VALID,
	input wire logic [1:0] RTS_A_SEL,
	input wire logic [1:0] RTS_B_SEL,
	input wire logic XRV_SEL,
	output logic REALTIME_STATUS_PIN_A,
	output logic REALTIME_STATUS_PIN_B,
	output logic REALTIME_CONTROL_OUT,
	output logic EXPANSION_HORIZONTAL_REF,
	output logic EXPANSION_VERTICAL_REF,
	output logic EXPANSION_DATA_QUALIFIER,
	output logic [7:0] EXPANSION_PIXEL_DATA,
	output logic RAW_DATA_MARKER,
	output logic VBI_DATA_MARKER
);
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0] line_type_r [0:ENTRY_COUNT-1];
	logic [10:0] horizontal_pixel_offset_r;
	logic [8:0] vertical_line_offset_r;
	logic field_offset_flag_r;
	logic field_odd_r;
	logic [4:0] wr_idx;
	logic wr_lt;

	assign wr_lt = (REG_ADDR >= LINE_TYPE_FIRST_ADDR) &&
		(REG_ADDR <= LINE_TYPE_LAST_ADDR);
	assign wr_idx = 5'(REG_ADDR - LINE_TYPE_FIRST_ADDR);

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			for (int i = 0; i < ENTRY_COUNT; i++) begin
				line_type_r[i] <= LINE_TYPE_RESET;
			end
		end else if (REG_WR && wr_lt) begin
			line_type_r[wr_idx] <= REG_WDATA;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			horizontal_pixel_offset_r <= HORIZONTAL_PIXEL_OFFSET_RESET;
			vertical_line_offset_r <= VERTICAL_LINE_OFFSET_RESET;
			field_offset_flag_r <= FIELD_OFFSET_FLAG_RESET;
		end else if (REG_WR) begin
			if (REG_ADDR == HORIZONTAL_OFFSET_LOW_ADDR) begin
				horizontal_pixel_offset_r[7:0] <= REG_WDATA;
			end
			if (REG_ADDR == VERTICAL_OFFSET_LOW_ADDR) begin
				vertical_line_offset_r[7:0] <= REG_WDATA;
			end
			if (REG_ADDR == OFFSET_HIGH_AND_FIELD_FLAG_ADDR) begin
				field_offset_flag_r <= REG_WDATA[FIELD_OFFSET_FLAG_BIT];
				vertical_line_offset_r[8] <= REG_WDATA[VERTICAL_LINE_OFFSET_HIGH_BIT];
				horizontal_pixel_offset_r[10:8] <= REG_WDATA[HORIZONTAL_PIXEL_OFFSET_HIGH_MSB:0];
			end
		end
	end

	// Unmapped and reserved bits read as zero
	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			REG_RDATA <= 8'h00;
			if (wr_lt) begin
				REG_RDATA <= line_type_r[wr_idx];
			end else if (REG_ADDR == HORIZONTAL_OFFSET_LOW_ADDR) begin
				REG_RDATA <= horizontal_pixel_offset_r[7:0];
			end else if (REG_ADDR == VERTICAL_OFFSET_LOW_ADDR) begin
				REG_RDATA <= vertical_line_offset_r[7:0];
			end else if (REG_ADDR == OFFSET_HIGH_AND_FIELD_FLAG_ADDR) begin
				REG_RDATA[FIELD_OFFSET_FLAG_BIT] <= field_offset_flag_r;
				REG_RDATA[FIELD_STATUS_BIT] <= field_odd_r;
				REG_RDATA[VERTICAL_LINE_OFFSET_HIGH_BIT] <= vertical_line_offset_r[8];
				REG_RDATA[HORIZONTAL_PIXEL_OFFSET_HIGH_MSB:0] <= horizontal_pixel_offset_r[10:8];
			end
		end
	end

	// ------------------------------------------------------------
	// Line and field tracking
	// ------------------------------------------------------------
	logic horizontal_reference_d_r;
	logic vs_d_r;
	logic parity_known_r;
	logic [10:0] pix_cnt_r;
	logic [9:0] line_cnt_r;
	logic line_tick;

	assign line_tick = (pix_cnt_r == horizontal_pixel_offset_r);

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			horizontal_reference_d_r <= 1'b0;
			vs_d_r <= 1'b0;
			pix_cnt_r <= 11'h000;
		end else begin
			horizontal_reference_d_r <= HORIZONTAL_REFERENCE;
			vs_d_r <= VERTICAL_SYNC_PULSE;
			// Counter restarts on each line start edge
			if (HORIZONTAL_REFERENCE && !horizontal_reference_d_r) begin
				pix_cnt_r <= 11'h000;
			end else if (pix_cnt_r != 11'h7FF) begin
				pix_cnt_r <= pix_cnt_r + 11'h001;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			line_cnt_r <= 10'h000;
		end else if (VERTICAL_SYNC_PULSE && !vs_d_r) begin
			line_cnt_r <= 10'h000;
		end else if (line_tick && line_cnt_r != 10'h3FF) begin
			line_cnt_r <= line_cnt_r + 10'h001;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			field_odd_r <= 1'b1;
			parity_known_r <= 1'b0;
		end else if (!VERTICAL_SYNC_PULSE && vs_d_r) begin
			field_odd_r <= HORIZONTAL_REFERENCE;
			parity_known_r <= 1'b1;
		end else if (VERTICAL_SYNC_PULSE && !vs_d_r) begin
			parity_known_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Entry selection
	// ------------------------------------------------------------
	logic [9:0] rel_line;
	logic [4:0] entry;
	logic sel_odd;
	logic [3:0] cur_code;
	logic raw_c;
	logic vbi_c;

	assign rel_line = line_cnt_r - {1'b0, vertical_line_offset_r};

	always_comb begin
		if (line_cnt_r < {1'b0, vertical_line_offset_r}) begin
			entry = ENTRY_REST;
		end else if (rel_line > 10'(ENTRY_LAST_SINGLE - ENTRY_FIRST)) begin
			entry = ENTRY_REST;
		end else begin
			entry = 5'(rel_line) + ENTRY_FIRST;
		end
	end

	// early lines belong to the other field
	assign sel_odd = (field_offset_flag_r && !parity_known_r) ? ~field_odd_r : field_odd_r;

	assign cur_code = sel_odd ? line_type_r[entry - ENTRY_FIRST][7:4] :
		line_type_r[entry - ENTRY_FIRST][3:0];

	dof_type_decode u_decode (
		.code(cur_code),
		.raw_mark(raw_c),
		.vbi_mark(vbi_c)
	);

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			RAW_DATA_MARKER <= 1'b0;
			VBI_DATA_MARKER <= 1'b0;
		end else begin
			RAW_DATA_MARKER <= raw_c;
			VBI_DATA_MARKER <= vbi_c;
		end
	end

	// ------------------------------------------------------------
	// Reference routing
	// ------------------------------------------------------------
	logic itu_field_flag;
	logic field_identifier;

	assign itu_field_flag = ~field_odd_r;
	assign field_identifier = field_odd_r;

	function automatic logic rts_pick(input logic [1:0] sel,
		input logic h, input logic v, input logic g, input logic f);
		unique case (dof_rts_sel_t'(sel))
			RTS_HORIZONTAL_REFERENCE: rts_pick = h;
			RTS_VSYNC: rts_pick = v;
			RTS_VERTICAL_WINDOW_GATE: rts_pick = g;
			RTS_FID: rts_pick = f;
		endcase
	endfunction

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			REALTIME_STATUS_PIN_A <= 1'b0;
			REALTIME_STATUS_PIN_B <= 1'b0;
			REALTIME_CONTROL_OUT <= 1'b0;
			EXPANSION_HORIZONTAL_REF <= 1'b0;
			EXPANSION_VERTICAL_REF <= 1'b0;
		end else begin
			REALTIME_STATUS_PIN_A <= rts_pick(RTS_A_SEL, HORIZONTAL_REFERENCE,
				VERTICAL_SYNC_PULSE, VERTICAL_WINDOW_GATE, field_identifier);
			REALTIME_STATUS_PIN_B <= rts_pick(RTS_B_SEL, HORIZONTAL_REFERENCE,
				VERTICAL_SYNC_PULSE, VERTICAL_WINDOW_GATE, field_identifier);
			REALTIME_CONTROL_OUT <= field_identifier;
			EXPANSION_HORIZONTAL_REF <= HORIZONTAL_REFERENCE;
			EXPANSION_VERTICAL_REF <= XRV_SEL ? itu_field_flag :
				VERTICAL_SYNC_PULSE;
		end
	end

	// ------------------------------------------------------------
	// Expansion data stream
	// ------------------------------------------------------------
	// stream formatter
	dof_itu_fmt u_fmt (
		.clk(MCLK),
		.rst_n(RESETN),
		.horizontal_reference(HORIZONTAL_REFERENCE),
		.f_bit(itu_field_flag),
		.v_bit(~VERTICAL_WINDOW_GATE),
		.data_in(VIDEO_DATA),
		.data_valid(VIDEO_VALID),
		.xpd(EXPANSION_PIXEL_DATA),
		.expansion_data_qualifier(EXPANSION_DATA_QUALIFIER)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);

	a_field_parity: assert property (
		$fell(VERTICAL_SYNC_PULSE) |=> field_odd_r == $past(HORIZONTAL_REFERENCE))
		else $error("field parity not taken at sync fall");
	a_raw_marker: assert property (
		(cur_code == TYPE_VBI_VIDEO || cur_code == TYPE_ACTIVE_VIDEO)
		|=> !RAW_DATA_MARKER)
		else $error("component type gave raw marker");
	a_raw_other: assert property (
		(cur_code != TYPE_VBI_VIDEO && cur_code != TYPE_ACTIVE_VIDEO)
		|=> RAW_DATA_MARKER && VBI_DATA_MARKER)
		else $error("raw type missing markers");
	a_entry_tail: assert property (
		(line_cnt_r >= 10'({1'b0, vertical_line_offset_r}) + 10'd23) |-> entry == ENTRY_REST)
		else $error("tail line not on last entry");
	a_entry_first: assert property (
		(line_cnt_r == {1'b0, vertical_line_offset_r}) |-> entry == ENTRY_FIRST)
		else $error("offset line not on first entry");
	a_nibble_sel: assert property (
		(sel_odd && entry == ENTRY_REST) |->
		cur_code == line_type_r[ENTRY_COUNT-1][7:4])
		else $error("field 1 nibble not used");
	a_route_xrh: assert property (
		HORIZONTAL_REFERENCE |=> EXPANSION_HORIZONTAL_REF)
		else $error("horizontal pin not following reference");
	a_route_xrv: assert property (
		(XRV_SEL && !field_odd_r) |=> EXPANSION_VERTICAL_REF)
		else $error("field flag not on vertical pin");
	a_vertical_line_offset_write: assert property (
		(REG_WR && REG_ADDR == VERTICAL_OFFSET_LOW_ADDR) |=>
		vertical_line_offset_r[7:0] == $past(REG_WDATA))
		else $error("vertical offset not stored");
	a_line_restart: assert property (
		$rose(VERTICAL_SYNC_PULSE) |=> line_cnt_r == 10'h000 [*1])
		else $error("line count not cleared at field start");

	c_odd_field: cover property ($fell(VERTICAL_SYNC_PULSE) ##1 field_odd_r);
	c_raw_line: cover property (RAW_DATA_MARKER ##1 !RAW_DATA_MARKER);
	c_rest_entry: cover property (entry == ENTRY_FIRST ##[1:1000]
		entry == ENTRY_REST);
endmodule
`default_nettype wire

// *** verification/dof_itu_rx.sv ***
// Expansion-port receiver model: watches the ITU 656 byte stream.
// Assumes bytes are sampled on every rising edge of the shared clock.
`timescale 1ns/1ps
`default_nettype none
module dof_itu_rx
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] data,
	output logic [7:0] sav_cnt,
	output logic [7:0] eav_cnt,
	output logic [7:0] bad_cnt,
	output logic last_f
);
	// ----------------------------------------
	// Code word detection
	// ----------------------------------------
	logic [23:0] hist_r;
	logic [3:0] prot;
	logic is_code;
	// Protection bits recomputed from F, V and H
	assign prot = {data[5] ^ data[4], data[6] ^ data[4], data[6] ^ data[5],
		data[6] ^ data[5] ^ data[4]};
	assign is_code = (hist_r == 24'hFF0000);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hist_r <= 24'h000000;
		end else begin
			hist_r <= {hist_r[15:0], data};
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sav_cnt <= 8'h00;
			eav_cnt <= 8'h00;
			bad_cnt <= 8'h00;
			last_f <= 1'b0;
		end else if (is_code) begin
			last_f <= data[6];
			if (!data[7] || data[3:0] != prot) begin
				bad_cnt <= bad_cnt + 8'h01;
			end else if (data[4]) begin
				eav_cnt <= eav_cnt + 8'h01;
			end else begin
				sav_cnt <= sav_cnt + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// *** verification/tb_decoder_output_formatter.sv ***
// Self-checking bench for the decoder output formatter.
// Assumes the receiver model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_decoder_output_formatter
	import dof_pkg::*;
;
	logic mclk, resetn, wr_s, rd_s, horizontal_reference, vsync, vertical_window_gate, vvalid, xrv_sel;
	logic [7:0] addr_s, wdata_s, rdata, vdata, xpd, rd;
	logic [1:0] sel_a, sel_b;
	logic pin_a, pin_b, ctrl_out, expansion_horizontal_ref, expansion_vertical_ref, expansion_data_qualifier, raw_mk, vbi_mk, last_f;
	logic [7:0] sav_cnt, eav_cnt, bad_cnt;
	int fails, samples_checked;

	dof_top i_dof_top (.MCLK(mclk), .RESETN(resetn), .REG_ADDR(addr_s),
		.REG_WDATA(wdata_s), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
		.HORIZONTAL_REFERENCE(horizontal_reference), .VERTICAL_SYNC_PULSE(vsync),
		.VERTICAL_WINDOW_GATE(vertical_window_gate), .VIDEO_DATA(vdata),
		.VIDEO_VALID(vvalid), .RTS_A_SEL(sel_a), .RTS_B_SEL(sel_b),
		.XRV_SEL(xrv_sel), .REALTIME_STATUS_PIN_A(pin_a),
		.REALTIME_STATUS_PIN_B(pin_b), .REALTIME_CONTROL_OUT(ctrl_out),
		.EXPANSION_HORIZONTAL_REF(expansion_horizontal_ref), .EXPANSION_VERTICAL_REF(expansion_vertical_ref),
		.EXPANSION_DATA_QUALIFIER(expansion_data_qualifier), .EXPANSION_PIXEL_DATA(xpd),
		.RAW_DATA_MARKER(raw_mk), .VBI_DATA_MARKER(vbi_mk));
	dof_itu_rx i_dof_itu_rx (.clk(mclk), .rst_n(resetn), .data(xpd),
		.sav_cnt(sav_cnt), .eav_cnt(eav_cnt), .bad_cnt(bad_cnt),
		.last_f(last_f));

	// ----------------------------------------
	// Clock, watchdog and verdict
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Whole run is near 1030 cycles; ten thousand leaves ample slack
	initial begin
		#100000;
		fails++;
		conclude();
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Compare and register tasks
	// ----------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		addr_s = a;
		wdata_s = d;
		wr_s = 1'b1;
		@(negedge mclk);
		wr_s = 1'b0;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		addr_s = a;
		rd_s = 1'b1;
		@(negedge mclk);
		rd_s = 1'b0;
		d = rdata;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_regs();
		logic [7:0] ad [5] = '{8'h59, 8'h5A, 8'h41, 8'h57, 8'h58};
		logic [7:0] ex [5] = '{8'h47, 8'h03, 8'hFF, 8'hFF, 8'h00};
		for (int i = 0; i < 5; i++) begin
			read_reg(ad[i], rd);
			chk8(rd, ex[i], "reset value");
		end
		read_reg(8'h5B, rd);
		chk8(rd & 8'hBF, 8'h03, "offset high reset");
	endtask
	task automatic t_write_back();
		// Bits 5 and 3 are unused and bit 6 is status only
		write_reg(8'h5B, 8'hFF);
		read_reg(8'h5B, rd);
		chk8(rd & 8'hBF, 8'h97, "offset high bits");
		write_reg(8'h59, 8'h0C);
		write_reg(8'h5A, 8'h00);
		write_reg(8'h5B, 8'h00);
		read_reg(8'h59, rd);
		chk8(rd, 8'h0C, "horizontal_pixel_offset low");
		for (int k = 1; k <= 22; k++) begin
			write_reg(8'h41 + k[7:0], {k[3:0], ~k[3:0]});
		end
	endtask
	// One field: a parity pulse at vsync fall, then n lines of 30 cycles
	task automatic run_field(input logic odd, input int n);
		int k;
		logic [3:0] c;
		@(negedge mclk);
		vsync = 1'b1;
		vertical_window_gate = 1'b0;
		repeat (3) @(negedge mclk);
		horizontal_reference = odd;
		repeat (6) @(negedge mclk);
		vsync = 1'b0;
		repeat (2) @(negedge mclk);
		horizontal_reference = 1'b0;
		repeat (6) @(negedge mclk);
		read_reg(8'h5B, rd);
		chk1(rd[6], odd, "parity status");
		chk1(ctrl_out, odd, "field id pin");
		vertical_window_gate = 1'b1;
		for (int j = 1; j <= n; j++) begin
			horizontal_reference = 1'b1;
			vvalid = j[0];
			repeat (20) @(negedge mclk);
			// Odd parity pulse restarts the pixel count, so its tick after vsync fall counts a line
			k = (j + int'(odd) > 22) ? 22 : j + int'(odd);
			c = odd ? k[3:0] : ~k[3:0];
			chk1(raw_mk, c != 4'h6 && c != 4'hF, "raw marker");
			chk1(vbi_mk, c != 4'hF, "vbi marker");
			chk8(xpd, 8'h55, "active sample");
			chk1(expansion_data_qualifier, j[0], "sample qualifier");
			horizontal_reference = 1'b0;
			repeat (10) @(negedge mclk);
		end
		vvalid = 1'b1;
		chk1(last_f, !odd, "code field bit");
		chk8(sav_cnt, eav_cnt, "start and end codes");
		chk8(bad_cnt, 8'h00, "malformed codes");
	endtask
	task automatic route_chk(input logic [1:0] s, input logic [2:0] p);
		logic [3:0] src;
		@(negedge mclk);
		horizontal_reference = p[2];
		vsync = p[1];
		vertical_window_gate = p[0];
		sel_a = s;
		sel_b = ~s;
		xrv_sel = s[0];
		repeat (2) @(negedge mclk);
		// Field id stays even: vsync only falls while horizontal_reference is low
		src = {1'b0, p[0], p[1], p[2]};
		chk1(pin_a, src[s], "pin a");
		chk1(pin_b, src[~s], "pin b");
		chk1(expansion_horizontal_ref, p[2], "expansion h");
		chk1(expansion_vertical_ref, s[0] ? 1'b1 : p[1], "expansion v");
	endtask
	// Recommended field setups; entry 24 holds 6 above, 9 below
	task automatic t_std_offsets();
		@(negedge mclk);
		vsync = 1'b1;
		write_reg(8'h5A, 8'h06);
		write_reg(8'h5B, 8'h80);
		read_reg(8'h5B, rd);
		chk8(rd & 8'hBF, 8'h80, "60 Hz flag set");
		@(negedge mclk);
		chk1(raw_mk, 1'b0, "flag swaps field nibble");
		write_reg(8'h5B, 8'h00);
		write_reg(8'h5A, 8'h03);
		repeat (2) @(negedge mclk);
		chk1(raw_mk, 1'b1, "flag clear keeps nibble");
		vsync = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	task automatic t_route();
		for (int s = 0; s < 4; s++) begin
			route_chk(s[1:0], 3'b100);
			route_chk(s[1:0], 3'b011);
			route_chk(s[1:0], 3'b000);
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		fails = 0;
		samples_checked = 0;
		resetn = 1'b0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		addr_s = 8'h00;
		wdata_s = 8'h00;
		horizontal_reference = 1'b0;
		vsync = 1'b0;
		vertical_window_gate = 1'b0;
		vdata = 8'h55;
		vvalid = 1'b1;
		sel_a = 2'h0;
		sel_b = 2'h1;
		xrv_sel = 1'b0;
		repeat (4) @(negedge mclk);
		chk8(xpd, ITU_BLANK_CHROMA, "blank in reset");
		resetn = 1'b1;
		t_reset_regs();
		t_write_back();
		run_field(1'b1, 23);
		run_field(1'b0, 6);
		t_route();
		t_std_offsets();
		conclude();
	end
endmodule
`default_nettype wire
